// ### logic/pbcs_pkg.sv
// Purpose: Shared constants for the base clock selector and its PLL
//          control registers.
// Assumes: Eight-bit register data on a three-bit word address.
// Notes:   Every offset, field position and count is here, with the reset values of the writable fields.

package pbcs_pkg;

  // ***********************************************************************
  // Register offsets
  // ***********************************************************************
  localparam logic [2:0] ADDR_CONTROL   = 3'h0;
  localparam logic [2:0] ADDR_BANDWIDTH = 3'h1;
  localparam logic [2:0] ADDR_MULT_HIGH = 3'h2;
  localparam logic [2:0] ADDR_MULT_LOW  = 3'h3;
  localparam logic [2:0] ADDR_VCO_RANGE = 3'h4;

  // ***********************************************************************
  // Field positions
  // ***********************************************************************
  localparam int CTL_IRQ_ENABLE = 7;
  localparam int CTL_LOCK_FLAG  = 6;
  localparam int CTL_PLL_POWER  = 5;
  localparam int CTL_BASE_SEL   = 4;
  localparam int CTL_RANGE_MSB  = 1;
  localparam int CTL_RANGE_LSB  = 0;
  localparam int BW_AUTO        = 7;
  localparam int BW_LOCK        = 6;
  localparam int BW_ACQ_TRACK   = 5;
  localparam int MULT_HIGH_MSB  = 3;

  // ***********************************************************************
  // Reset values
  // ***********************************************************************
  localparam logic       RST_PLL_POWER = 1'b1;
  localparam logic       RST_BASE_SEL  = 1'b0;
  localparam logic       RST_IRQ_EN    = 1'b0;
  localparam logic       RST_AUTO      = 1'b0;
  localparam logic       RST_ACQ_TRACK = 1'b0;
  localparam logic [1:0] RST_RANGE_EXP = 2'h0;
  localparam logic [3:0] RST_MULT_HIGH = 4'h0;
  localparam logic [7:0] RST_MULT_LOW  = 8'h40;
  localparam logic [7:0] RST_LINEAR    = 8'h40;

  // ***********************************************************************
  // Source switch timing
  // ***********************************************************************
  localparam logic [1:0] SWITCH_EDGES  = 2'h3;

  typedef enum logic [1:0]
  {
    ST_RUN  = 2'b00,
    ST_HOLD = 2'b01
  } pbcs_sw_state_type;

endpackage

// ### logic/pbcs_sync_edge.sv
// Purpose: Two-stage synchroniser with edge and toggle detection.
// Assumes: Input is asynchronous to i_core_clk.
// Notes:   The first stage feeds only the second stage.

`timescale 1ns/100ps

module pbcs_sync_edge (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // Asynchronous input
  input  wire logic i_async,
  // Synchronised results
  output logic      o_level,
  output logic      o_rise,
  output logic      o_toggle
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ***********************************************************************
  // Synchroniser chain
  // ***********************************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign o_level  = sync_r;
  assign o_rise   = sync_r & ~prev_r;
  assign o_toggle = sync_r ^ prev_r;

endmodule

// ### logic/pbcs_top.sv
// Purpose: PLL control registers, interlocks and glitch-free base clock
//          selection between the crystal clock and the VCO clock.
// Assumes: Source clocks are well below a quarter of i_core_clk.
// Notes:   Base clock edges are resampled on the core clock.
//
// How it works
// [RL1] A feedback multiplier of zero is sent out as one.
// [RL2] Linear range zero disables the PLL and forces the crystal source.
// [RL3] On source change hold the output for three crystal edges and, while the PLL is enabled, three VCO edges.
// [RL4] The selected source is divided by two for an even duty output.
// [RL5] base_select picks crystal clock or VCO clock as base source.
// [RL6] VCO selection is refused while pll_power is off.
// [RL7] Switching the PLL off is refused while the VCO is selected.
// [RL8] Power and selection cannot change in the same write.
// [RL9] Oscillator and PLL run only while osc_enable_in or osc_stop_keep is high.
// [RL10] osc_stop_keep keeps the oscillator running through stop mode.
// [RL11] pll_irq comes from the lock detector path.
// [RL12] irq_enable reads zero and ignores writes in manual bandwidth.
// [RL13] Manual bandwidth makes lock flag and lock indicator read zero.
// [RL14] base_select forced zero while power off or linear range zero.
// [RL15] Multiplier and range fields are read-only while PLL is on.
// [RL16] pll_power forced on while base_select is set.
// [RL17] Software writes the power-of-two exponent into range_exp.
// [RL18] Software splits the multiplier over the two multiplier registers.
// [RL19] Software writes the linear range into the VCO range register.
// [RL20] Software reprograms multiplier_low before enabling the PLL.
// [RL21] Automatic mode reports the detector filter state on acq_track.
// [RL22] Lock toggle sets the flag, raises irq, read of control clears.
// [RL23] Reset turns pll_power on.
// [RL24] Reset clears acq_track, selecting acquisition mode.
// [RL25] A blocked bit keeps its value while other bits still update.
// [RL26] Source clocks are synchronised before the output may switch.

`timescale 1ns/100ps

module pbcs_top (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // Register port
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  output logic      [7:0] o_rd_data,
  // System integration controls
  input  wire logic       i_osc_enable_in,
  input  wire logic       i_osc_stop_keep,
  // Source clocks
  input  wire logic       i_crystal_clock,
  input  wire logic       i_vco_clock,
  // Lock detector
  input  wire logic       i_lock_detect,
  input  wire logic       i_track_detect,
  // Clock and interrupt outputs
  output logic            o_base_clock_out,
  output logic            o_pll_irq,
  // Analog control outputs
  output logic            o_osc_enable,
  output logic            o_pll_enable,
  output logic     [11:0] o_feedback_divider,
  output logic      [1:0] o_range_exp,
  output logic      [7:0] o_linear_range,
  output logic            o_filter_track,
  output logic            o_auto_bw
);

  // ***********************************************************************
  // Declarations
  // ***********************************************************************
  logic                           irq_enable_r;
  logic                           lock_flag_r;
  logic                           pll_power_r;
  logic                           base_select_r;
  logic                     [1:0] range_exp_r;
  logic                           auto_r;
  logic                           acq_manual_r;
  logic                     [3:0] mult_high_r;
  logic                     [7:0] mult_low_r;
  logic                     [7:0] linear_r;
  logic                     [7:0] rd_data_r;
  logic                     [7:0] rd_data_nxt;
  logic                           pll_irq_r;
  logic                           osc_enable_r;
  logic                           pll_enable_r;
  logic                    [11:0] feedback_r;
  logic                           filter_track_r;
  logic                           base_out_r;
  logic                           active_src_r;
  logic                     [1:0] xtal_cnt_r;
  logic                     [1:0] vco_cnt_r;
  pbcs_pkg::pbcs_sw_state_type    sw_state_r;

  logic                           wr_ctl;
  logic                           wr_bw;
  logic                           wr_mh;
  logic                           wr_ml;
  logic                           wr_vr;
  logic                           rd_ctl;
  logic                           linear_zero;
  logic                           wr_power;
  logic                           wr_select;
  logic                           osc_run;
  logic                    [11:0] mult_full;
  logic                           lock_level;
  logic                           lock_toggle;
  logic                           track_level;
  logic                           xtal_rise;
  logic                           vco_rise;
  logic                           acq_read;

  // ***********************************************************************
  // Synchronisers
  // ***********************************************************************
  pbcs_sync_edge u_sync_xtal (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    (i_crystal_clock),
    .o_level    (),
    .o_rise     (xtal_rise),
    .o_toggle   ()
  );

  pbcs_sync_edge u_sync_vco (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    (i_vco_clock),
    .o_level    (),
    .o_rise     (vco_rise),
    .o_toggle   ()
  );

  pbcs_sync_edge u_sync_lock (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    (i_lock_detect),
    .o_level    (lock_level),
    .o_rise     (),
    .o_toggle   (lock_toggle)
  );

  pbcs_sync_edge u_sync_track (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    (i_track_detect),
    .o_level    (track_level),
    .o_rise     (),
    .o_toggle   ()
  );

  // ***********************************************************************
  // Decode
  // ***********************************************************************
  assign wr_ctl      = i_wr_en && (i_addr == pbcs_pkg::ADDR_CONTROL);
  assign wr_bw       = i_wr_en && (i_addr == pbcs_pkg::ADDR_BANDWIDTH);
  assign wr_mh       = i_wr_en && (i_addr == pbcs_pkg::ADDR_MULT_HIGH);
  assign wr_ml       = i_wr_en && (i_addr == pbcs_pkg::ADDR_MULT_LOW);
  assign wr_vr       = i_wr_en && (i_addr == pbcs_pkg::ADDR_VCO_RANGE);
  assign rd_ctl      = i_rd_en && (i_addr == pbcs_pkg::ADDR_CONTROL);
  assign wr_power    = i_wr_data[pbcs_pkg::CTL_PLL_POWER];
  assign wr_select   = i_wr_data[pbcs_pkg::CTL_BASE_SEL];
  assign linear_zero = (linear_r == 8'h00);
  assign mult_full   = {mult_high_r, mult_low_r};
  assign acq_read    = auto_r ? track_level : acq_manual_r; // [RL21]

  // ***********************************************************************
  // Control register
  // ***********************************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      irq_enable_r <= pbcs_pkg::RST_IRQ_EN;
    else if (!auto_r)
      irq_enable_r <= 1'b0; // [RL12]
    else if (wr_ctl)
      irq_enable_r <= i_wr_data[pbcs_pkg::CTL_IRQ_ENABLE];
  end

  // A write that would really move base_select leaves power alone.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      pll_power_r <= pbcs_pkg::RST_PLL_POWER; // [RL23]
    else if (wr_ctl && !base_select_r && (!wr_select || !pll_power_r))
      pll_power_r <= wr_power; // [RL7] [RL16] [RL8] [RL25]
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      base_select_r <= pbcs_pkg::RST_BASE_SEL;
    else if (!pll_power_r || linear_zero)
      base_select_r <= 1'b0; // [RL6] [RL14] [RL2]
    else if (wr_ctl && (wr_power == pll_power_r))
      base_select_r <= wr_select; // [RL5] [RL8] [RL25]
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      range_exp_r <= pbcs_pkg::RST_RANGE_EXP;
    else if (wr_ctl && !pll_power_r)
      range_exp_r <= i_wr_data[pbcs_pkg::CTL_RANGE_MSB:
                               pbcs_pkg::CTL_RANGE_LSB]; // [RL15] [RL17]
  end

  // The set beats a simultaneous clearing read so no lock change is lost.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      lock_flag_r <= 1'b0;
    else if (!auto_r)
      lock_flag_r <= 1'b0; // [RL13]
    else if (lock_toggle)
      lock_flag_r <= 1'b1; // [RL22]
    else if (rd_ctl)
      lock_flag_r <= 1'b0; // [RL22]
  end

  // ***********************************************************************
  // Bandwidth register
  // ***********************************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      auto_r <= pbcs_pkg::RST_AUTO;
    else if (wr_bw)
      auto_r <= i_wr_data[pbcs_pkg::BW_AUTO];
  end

  // The manual value survives automatic mode and returns with manual mode.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      acq_manual_r <= pbcs_pkg::RST_ACQ_TRACK; // [RL24]
    else if (wr_bw && !auto_r)
      acq_manual_r <= i_wr_data[pbcs_pkg::BW_ACQ_TRACK]; // [RL25]
  end

  // ***********************************************************************
  // Programming registers
  // ***********************************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      mult_high_r <= pbcs_pkg::RST_MULT_HIGH;
      mult_low_r  <= pbcs_pkg::RST_MULT_LOW;
      linear_r    <= pbcs_pkg::RST_LINEAR;
    end
    else if (!pll_power_r)
    begin
      if (wr_mh)
        mult_high_r <= i_wr_data[pbcs_pkg::MULT_HIGH_MSB:0]; // [RL15] [RL18]
      if (wr_ml)
        mult_low_r <= i_wr_data; // [RL15] [RL18] [RL20]
      if (wr_vr)
        linear_r <= i_wr_data; // [RL15] [RL19]
    end
  end

  // ***********************************************************************
  // Read port
  // ***********************************************************************
  always_comb
  begin
    rd_data_nxt = 8'h00;
    case (i_addr)
      pbcs_pkg::ADDR_CONTROL:
      begin
        rd_data_nxt[pbcs_pkg::CTL_IRQ_ENABLE] = irq_enable_r & auto_r;
        rd_data_nxt[pbcs_pkg::CTL_LOCK_FLAG]  = lock_flag_r & auto_r;
        rd_data_nxt[pbcs_pkg::CTL_PLL_POWER]  = pll_power_r;
        rd_data_nxt[pbcs_pkg::CTL_BASE_SEL]   = base_select_r;
        rd_data_nxt[pbcs_pkg::CTL_RANGE_MSB:
                    pbcs_pkg::CTL_RANGE_LSB]  = range_exp_r;
      end
      pbcs_pkg::ADDR_BANDWIDTH:
      begin
        rd_data_nxt[pbcs_pkg::BW_AUTO]      = auto_r;
        rd_data_nxt[pbcs_pkg::BW_LOCK]      = lock_level & auto_r; // [RL13]
        rd_data_nxt[pbcs_pkg::BW_ACQ_TRACK] = acq_read; // [RL21]
      end
      pbcs_pkg::ADDR_MULT_HIGH:
        rd_data_nxt[pbcs_pkg::MULT_HIGH_MSB:0] = mult_high_r;
      pbcs_pkg::ADDR_MULT_LOW:
        rd_data_nxt = mult_low_r;
      pbcs_pkg::ADDR_VCO_RANGE:
        rd_data_nxt = linear_r;
      default:
        rd_data_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      rd_data_r <= 8'h00;
    else if (i_rd_en)
      rd_data_r <= rd_data_nxt;
    else
      rd_data_r <= 8'h00;
  end

  // ***********************************************************************
  // Interrupt and analog controls
  // ***********************************************************************
  assign osc_run = i_osc_enable_in | i_osc_stop_keep; // [RL9] [RL10]

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      pll_irq_r <= 1'b0;
    else
      pll_irq_r <= lock_flag_r & irq_enable_r; // [RL11] [RL22]
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      osc_enable_r   <= 1'b0;
      pll_enable_r   <= 1'b0;
      feedback_r     <= 12'h001;
      filter_track_r <= pbcs_pkg::RST_ACQ_TRACK;
    end
    else
    begin
      osc_enable_r   <= osc_run; // [RL9] [RL10]
      pll_enable_r   <= pll_power_r & ~linear_zero & osc_run; // [RL2] [RL9]
      feedback_r     <= (mult_full == 12'h000) ? 12'h001 : mult_full; // [RL1]
      filter_track_r <= acq_read; // [RL21]
    end
  end

  // ***********************************************************************
  // Source transition control
  // ***********************************************************************
  // Edges are counted only after resampling, so a half-seen pulse of the
  // old source can never leak into the new one.
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      sw_state_r   <= pbcs_pkg::ST_RUN;
      active_src_r <= 1'b0;
      xtal_cnt_r   <= 2'h0;
      vco_cnt_r    <= 2'h0;
    end
    else
    begin
      case (sw_state_r)
        pbcs_pkg::ST_RUN:
        begin
          if (base_select_r != active_src_r)
          begin
            sw_state_r <= pbcs_pkg::ST_HOLD; // [RL3]
            xtal_cnt_r <= 2'h0;
            vco_cnt_r  <= 2'h0;
          end
        end
        pbcs_pkg::ST_HOLD:
        begin
          if (xtal_rise && (xtal_cnt_r != pbcs_pkg::SWITCH_EDGES))
            xtal_cnt_r <= xtal_cnt_r + 2'h1; // [RL26]
          if (vco_rise && (vco_cnt_r != pbcs_pkg::SWITCH_EDGES))
            vco_cnt_r <= vco_cnt_r + 2'h1; // [RL26]
          if ((xtal_cnt_r == pbcs_pkg::SWITCH_EDGES) &&
              ((vco_cnt_r == pbcs_pkg::SWITCH_EDGES) || !pll_enable_r))
          begin
            active_src_r <= base_select_r; // [RL3] [RL5]
            sw_state_r   <= pbcs_pkg::ST_RUN;
          end
        end
        default:
          sw_state_r <= pbcs_pkg::ST_RUN;
      endcase
    end
  end

  // ***********************************************************************
  // Divide by two
  // ***********************************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      base_out_r <= 1'b0;
    else if ((sw_state_r == pbcs_pkg::ST_RUN) &&
             (base_select_r == active_src_r))
    begin
      if (active_src_r ? vco_rise : xtal_rise)
        base_out_r <= ~base_out_r; // [RL4] [RL3]
    end
  end

  // ***********************************************************************
  // Outputs
  // ***********************************************************************
  assign o_rd_data          = rd_data_r;
  assign o_base_clock_out   = base_out_r;
  assign o_pll_irq          = pll_irq_r;
  assign o_osc_enable       = osc_enable_r;
  assign o_pll_enable       = pll_enable_r;
  assign o_feedback_divider = feedback_r;
  assign o_range_exp        = range_exp_r;
  assign o_linear_range     = linear_r;
  assign o_filter_track     = filter_track_r;
  assign o_auto_bw          = auto_r;

endmodule

// ### tb/pbcs_chk.sv
// Purpose: Port assertions for the base clock selector.
// Assumes: Source clocks run below a quarter of the core clock.
// Notes:   Bound to pbcs_top from the bench top file.

`timescale 1ns/100ps

module pbcs_chk (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Register port
  input  wire logic  [2:0] i_addr,
  input  wire logic        i_rd_en,
  input  wire logic  [7:0] o_rd_data,
  // Oscillator controls
  input  wire logic        i_osc_enable_in,
  input  wire logic        i_osc_stop_keep,
  // Watched outputs
  input  wire logic        o_base_clock_out,
  input  wire logic        o_pll_irq,
  input  wire logic        o_osc_enable,
  input  wire logic        o_pll_enable,
  input  wire logic [11:0] o_feedback_divider,
  input  wire logic  [1:0] o_range_exp,
  input  wire logic  [7:0] o_linear_range,
  input  wire logic        o_auto_bw
);
  // ********************
  // Properties
  // ********************
  logic osc_req;
  logic rd_ctl;
  logic rd_bw;
  assign osc_req = i_osc_enable_in | i_osc_stop_keep;
  assign rd_ctl  = i_rd_en && (i_addr == pbcs_pkg::ADDR_CONTROL);
  assign rd_bw   = i_rd_en && (i_addr == pbcs_pkg::ADDR_BANDWIDTH);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_div_one;
    o_feedback_divider != 12'h000;
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("feedback divider shows zero");
  property p_pll_range;
    o_pll_enable |-> o_linear_range != 8'h00;
  endproperty
  a_pll_range: assert property (p_pll_range)
    else $error("pll enabled with zero linear range");
  property p_pll_osc;
    o_pll_enable |-> $past(osc_req) || $past(osc_req, 2) || $past(osc_req, 3);
  endproperty
  a_pll_osc: assert property (p_pll_osc)
    else $error("pll enabled without oscillator enable");
  property p_osc_keep;
    !$past(i_rst) |-> o_osc_enable == $past(osc_req);
  endproperty
  a_osc_keep: assert property (p_osc_keep)
    else $error("oscillator enable wrong");
  // Sources are below a quarter of the core rate, so toggles stay apart.
  property p_half_rate;
    $changed(o_base_clock_out) |=> $stable(o_base_clock_out) [*3];
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("base clock toggles too fast");
  property p_irq_auto;
    o_pll_irq |-> o_auto_bw || $past(o_auto_bw) || $past(o_auto_bw, 2);
  endproperty
  a_irq_auto: assert property (p_irq_auto)
    else $error("interrupt in manual bandwidth");
  property p_bw_lock;
    $past(rd_bw) && !o_auto_bw && !$past(o_auto_bw) |-> o_rd_data[6] == 1'b0;
  endproperty
  a_bw_lock: assert property (p_bw_lock)
    else $error("lock reads set in manual bandwidth");
  property p_ctl_auto;
    $past(rd_ctl) && !o_auto_bw && !$past(o_auto_bw) |-> o_rd_data[7:6] == 2'h0;
  endproperty
  a_ctl_auto: assert property (p_ctl_auto)
    else $error("irq enable or flag set in manual bandwidth");
  property p_prog_ro;
    o_pll_enable && $past(o_pll_enable) |-> $stable(o_range_exp) &&
      $stable(o_linear_range) && $stable(o_feedback_divider);
  endproperty
  a_prog_ro: assert property (p_prog_ro)
    else $error("programming changed while pll on");
  c_toggle: cover property ($changed(o_base_clock_out));
  c_irq: cover property (o_pll_irq);
  c_flag: cover property ($past(rd_ctl) && o_rd_data[6]);
endmodule

// ### tb/pbcs_far_model.sv
// Purpose: Source clocks and lock detector beside the selector.
// Assumes: Clock edges fall on core clock falling edges.
// Notes:   Clocks stand still while their enable is low.

`timescale 1ns/100ps

module pbcs_far_model (
  // Enables from the selector
  input  wire logic i_osc_run,
  input  wire logic i_pll_run,
  // Bench commands
  input  wire logic i_lock_req,
  input  wire logic i_track_req,
  // Outputs to the selector
  output logic      o_crystal_clock,
  output logic      o_vco_clock,
  output logic      o_lock_detect,
  output logic      o_track_detect
);
  initial o_crystal_clock = 1'b0;
  initial o_vco_clock = 1'b0;
  // Halves of 120 ns and 80 ns keep edges off the core rising edge.
  always #120 if (i_osc_run) o_crystal_clock = ~o_crystal_clock;
  always #80 if (i_pll_run) o_vco_clock = ~o_vco_clock;
  assign o_lock_detect  = i_lock_req & i_pll_run;
  assign o_track_detect = i_track_req & i_pll_run;
endmodule

// ### tb/pbcs_tb_top.sv
// Purpose: Self-checking bench for the base clock selector.
// Assumes: 50 MHz core clock, synchronous reset.
// Notes:   Source periods are 12 and 8 core cycles.

`timescale 1ns/100ps

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end

module pbcs_tb_top;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic i_osc_enable_in = 1'b1;
  logic i_osc_stop_keep = 1'b0;
  logic lock_req = 1'b0;
  logic track_req = 1'b0;
  logic [7:0] o_rd_data;
  logic [11:0] o_feedback_divider;
  logic [1:0] o_range_exp;
  logic [7:0] o_linear_range;
  logic i_crystal_clock, i_vco_clock, i_lock_detect, i_track_detect;
  logic o_base_clock_out, o_pll_irq, o_osc_enable, o_pll_enable;
  logic o_filter_track, o_auto_bw;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  logic [7:0] q;
  logic v;
  logic stb;
  logic [7:0] rst_val [0:5] = '{8'h20, 8'h00, 8'h00, 8'h40, 8'h40, 8'h00};

  always #10 i_core_clk = ~i_core_clk;

  pbcs_top dut (.i_core_clk, .i_rst, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en,
    .o_rd_data, .i_osc_enable_in, .i_osc_stop_keep, .i_crystal_clock,
    .i_vco_clock, .i_lock_detect, .i_track_detect, .o_base_clock_out,
    .o_pll_irq, .o_osc_enable, .o_pll_enable, .o_feedback_divider,
    .o_range_exp, .o_linear_range, .o_filter_track, .o_auto_bw);

  pbcs_far_model far (.i_osc_run(o_osc_enable), .i_pll_run(o_pll_enable),
    .i_lock_req(lock_req), .i_track_req(track_req),
    .o_crystal_clock(i_crystal_clock), .o_vco_clock(i_vco_clock),
    .o_lock_detect(i_lock_detect), .o_track_detect(i_track_detect));

  // ********************
  // Bus and helper tasks
  // ********************
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    @(posedge i_core_clk);
    i_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_core_clk);
    i_rd_en <= 1'b0;
    @(negedge i_core_clk);
    d = o_rd_data;
  endtask

  task automatic pause(input int c);
    repeat (c) @(negedge i_core_clk);
  endtask

  // Bounded waits: a stuck output gives a gap of 300, not a hang.
  task automatic gap(output int c);
    @(negedge i_core_clk);
    v = o_base_clock_out;
    for (c = 0; c < 300 && o_base_clock_out === v; c++) pause(1);
    v = o_base_clock_out;
    for (c = 0; c < 300 && o_base_clock_out === v; c++) pause(1);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset;
    for (int i = 0; i < 6; i++)
    begin
      rd(i[2:0], q);
      `CHK(q, rst_val[i])
    end
    `CHK(o_feedback_divider, 12'h040)
  endtask

  task automatic t_program;
    wr(3'h3, 8'h10);
    rd(3'h3, q);
    `CHK(q, 8'h40)
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    pause(3);
    `CHK(o_feedback_divider, 12'h001)
    wr(3'h0, 8'h02);
    wr(3'h2, 8'h01);
    wr(3'h3, 8'h08);
    wr(3'h4, 8'h20);
    pause(3);
    `CHK(o_range_exp, 2'h2)
    `CHK(o_feedback_divider, 12'h108)
    `CHK(o_linear_range, 8'h20)
  endtask

  task automatic t_select;
    wr(3'h0, 8'h12);
    rd(3'h0, q);
    `CHK(q, 8'h02)
    wr(3'h0, 8'h32);
    rd(3'h0, q);
    `CHK(q, 8'h22)
    wr(3'h0, 8'h32);
    stb = 1'b1;
    pause(1);
    v = o_base_clock_out;
    for (int i = 0; i < 20; i++)
    begin
      pause(1);
      if (o_base_clock_out !== v) stb = 1'b0;
    end
    `CHK(stb, 1'b1)
    gap(n);
    `CHK(n, 8)
    wr(3'h0, 8'h02);
    rd(3'h0, q);
    `CHK(q, 8'h32)
    wr(3'h0, 8'h22);
    gap(n);
    `CHK(n, 12)
  endtask

  task automatic t_linear_zero;
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h0, 8'h20);
    wr(3'h0, 8'h30);
    rd(3'h0, q);
    `CHK(q, 8'h20)
    pause(3);
    `CHK(o_pll_enable, 1'b0)
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h20);
    wr(3'h0, 8'h20);
  endtask

  task automatic t_lock_irq;
    wr(3'h0, 8'hA0);
    rd(3'h0, q);
    `CHK(q, 8'h20)
    lock_req <= 1'b1;
    pause(8);
    rd(3'h1, q);
    `CHK(q, 8'h00)
    rd(3'h0, q);
    `CHK(q, 8'h20)
    wr(3'h1, 8'h80);
    wr(3'h0, 8'hA0);
    rd(3'h0, q);
    `CHK(q, 8'hA0)
    lock_req <= 1'b0;
    pause(8);
    `CHK(o_pll_irq, 1'b1)
    rd(3'h0, q);
    `CHK(q, 8'hE0)
    rd(3'h0, q);
    `CHK(q, 8'hA0)
    pause(2);
    `CHK(o_pll_irq, 1'b0)
    track_req <= 1'b1;
    pause(8);
    rd(3'h1, q);
    `CHK(q, 8'hA0)
    `CHK(o_filter_track, 1'b1)
    track_req <= 1'b0;
    wr(3'h1, 8'h20);
    wr(3'h1, 8'h20);
    rd(3'h1, q);
    `CHK(q, 8'h20)
  endtask

  task automatic t_oscillator;
    @(posedge i_core_clk);
    i_osc_enable_in <= 1'b0;
    pause(4);
    `CHK(o_osc_enable, 1'b0)
    `CHK(o_pll_enable, 1'b0)
    @(posedge i_core_clk);
    i_osc_stop_keep <= 1'b1;
    pause(4);
    `CHK(o_osc_enable, 1'b1)
    `CHK(o_pll_enable, 1'b1)
  endtask

  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  initial
  begin
    repeat (6) @(posedge i_core_clk);
    i_rst <= 1'b0;
    t_reset();
    t_program();
    t_select();
    t_linear_zero();
    t_lock_irq();
    t_oscillator();
    complete_run();
  end
endmodule

bind pbcs_top pbcs_chk u_chk (.i_core_clk, .i_rst, .i_addr, .i_rd_en,
  .o_rd_data, .i_osc_enable_in, .i_osc_stop_keep, .o_base_clock_out,
  .o_pll_irq, .o_osc_enable, .o_pll_enable, .o_feedback_divider,
  .o_range_exp, .o_linear_range, .o_auto_bw);
